// ===== bench/pfm_pad_model.sv
`timescale 1ns/10ps
module pfm_pad_model (
  input  wire logic clk,      // System clock
  input  wire logic pad_o,    // Design drive value
  input  wire logic pad_oe_n, // Design enable, low
  input  wire logic ext_en,   // Far side drives
  input  wire logic ext_val,  // Far side value
  input  wire logic pull_up,  // Pull-up present
  output logic      pad_i     // Resolved level
);
  logic last_r = 1'b0;
  // Undriven line without pull shows inverse of last driven level
  always_comb begin
    if (!pad_oe_n) pad_i = pad_o;
    else if (ext_en) pad_i = ext_val;
    else if (pull_up) pad_i = 1'b1;
    else pad_i = ~last_r;
  end
  always_ff @(posedge clk) begin
    if (!pad_oe_n || ext_en) last_r <= pad_i;
  end
endmodule

// ===== bench/tb.sv
`timescale 1ns/10ps
module tb;
  import pfm_pkg::*;
  logic        clk, rst_n, ms, trc, xrst_n, selw, tck, dclk, wm, pu, pd;
  logic [15:0] cfa, cfb, cfc;
  logic [7:0]  dcf, rmp, ccr;
  logic [1:0]  mode;
  logic        gb1, gb2, gc2, mosi, miso, utx, sda_n, scl_n, t1, t2;
  logic        tdo, atr, ib1, ib2, ic2, srx, urx, sda, scl, p1, p2;
  logic        b1i, b1o, b1e_n, b2i, b2o, b2e_n, c2i, c2o, c2e_n;
  logic [2:0]  xe, xv;
  int          err_total, checks;
  pfm_mux dut (
    .clk(clk), .rst_n(rst_n), .port_b_low_config(cfb),
    .port_a_low_config(cfa), .port_c_low_config(cfc),
    .debug_pin_config(dcf), .timer2_remap_option_reg(rmp),
    .timer2_capcomp_enable_reg(ccr), .serctl1_mode_select(mode),
    .serctl1_spi_control(ms), .trace_async_en(trc),
    .external_reset_pin_n(xrst_n), .dbg_select_wire(selw),
    .gpio_b1_out(gb1), .gpio_b2_out(gb2), .gpio_c2_out(gc2),
    .gpio_b1_in(ib1), .gpio_b2_in(ib2), .gpio_c2_in(ic2),
    .serctl1_spi_master_out_slave_in(mosi),
    .serctl1_spi_slave_out_master_in(miso), .serctl1_uart_tx(utx),
    .serctl1_twi_data_oe_n(sda_n), .serctl1_twi_clock_oe_n(scl_n),
    .serctl1_spi_rx(srx), .serctl1_uart_rx(urx), .serctl1_twi_data(sda),
    .serctl1_twi_clock(scl), .timer2_ch1_out(t1), .timer2_ch2_out(t2),
    .timer2_channel1_pin(p1), .timer2_channel2_pin(p2),
    .jtag_test_data_out(tdo), .async_trace_out(atr), .dbg_wire_mode(wm),
    .dbg_clock(dclk), .port_b_bit1_pad_i(b1i), .port_b_bit1_pad_o(b1o),
    .port_b_bit1_pad_oe_n(b1e_n), .port_b_bit2_pad_i(b2i),
    .port_b_bit2_pad_o(b2o), .port_b_bit2_pad_oe_n(b2e_n),
    .port_c_bit2_pad_i(c2i), .port_c_bit2_pad_o(c2o),
    .port_c_bit2_pad_oe_n(c2e_n), .port_c_bit2_pull_up(pu),
    .jtag_test_clock_pin(tck), .jtag_test_clock_pull_down(pd)
  );
  pfm_pad_model pad_b1 (.clk(clk), .pad_o(b1o), .pad_oe_n(b1e_n),
    .ext_en(xe[0]), .ext_val(xv[0]), .pull_up(1'b0), .pad_i(b1i));
  pfm_pad_model pad_b2 (.clk(clk), .pad_o(b2o), .pad_oe_n(b2e_n),
    .ext_en(xe[1]), .ext_val(xv[1]), .pull_up(1'b0), .pad_i(b2i));
  pfm_pad_model pad_c2 (.clk(clk), .pad_o(c2o), .pad_oe_n(c2e_n),
    .ext_en(xe[2]), .ext_val(xv[2]), .pull_up(pu), .pad_i(c2i));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task print_verdict();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task wait_wm(input logic e);
    for (int i = 0; i < 12 && wm !== e; i++) step(1);
    chk(wm, e);
    if (wm !== e) print_verdict();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_gpio();
    @(posedge clk); mode <= SC_MODE_OFF; cfb <= 16'h0010; gb1 <= 1'b1;
    step(2); chk(b1e_n, 1'b0); chk(b1o, 1'b1);
    @(posedge clk); cfb <= 16'h0040; xe[0] <= 1'b1; xv[0] <= 1'b0;
    step(6); chk(b1e_n, 1'b1); chk(ib1, 1'b0);
    chk(p1, 1'b0);
  endtask
  task t_spi();
    for (int m = 0; m < 2; m++) begin
      for (int v = 0; v < 2; v++) begin
        @(posedge clk); mode <= SC_MODE_SPI; ms <= m[0]; cfb <= 16'h0090;
        mosi <= v[0]; miso <= ~v[0]; xe <= 3'h2; xv[1] <= v[0];
        step(6); chk(b1e_n, 1'b0); chk(srx, v[0]);
        chk(b1o, m[0] ? v[0] : ~v[0]);
      end
    end
    @(posedge clk); cfb <= 16'h0040;
    step(2); chk(b1e_n, 1'b1);
  endtask
  task t_uart();
    @(posedge clk); mode <= SC_MODE_UART; cfb <= 16'h0090; utx <= 1'b0;
    xv[1] <= 1'b0; rmp <= 8'h10; ccr <= 8'h00;
    step(6); chk(b1o, 1'b0); chk(urx, 1'b0);
    @(posedge clk); utx <= 1'b1; xv[1] <= 1'b1;
    step(6); chk(b1o, 1'b1); chk(urx, 1'b1);
    @(posedge clk); ccr <= 8'h01;
    step(2); chk(b1e_n, 1'b1);
    @(posedge clk); cfa <= 16'h0090; t1 <= 1'b0;
    step(2); chk(b1e_n, 1'b0); chk(b1o, 1'b0);
    @(posedge clk); rmp <= 8'h00;
    step(2); chk(b1o, 1'b1);
    @(posedge clk); ccr <= 8'h00; cfa <= 16'h0000;
  endtask
  task t_twi();
    @(posedge clk); mode <= SC_MODE_TWI; cfb <= 16'h0DD0; sda_n <= 1'b0;
    scl_n <= 1'b0; xe <= 3'h3; xv <= 3'h3;
    step(2); chk(b1e_n, 1'b0); chk(b1o, 1'b0); chk(b2e_n, 1'b0);
    @(posedge clk); sda_n <= 1'b1; scl_n <= 1'b1;
    step(6); chk(b1e_n, 1'b1); chk(sda, 1'b1); chk(scl, 1'b1);
    @(posedge clk); xv <= 3'h0;
    step(6); chk(sda, 1'b0); chk(scl, 1'b0);
    @(posedge clk); rmp <= 8'h20; ccr <= 8'h10;
    step(6); chk(scl, 1'b1);
    @(posedge clk); rmp <= 8'h00; ccr <= 8'h00; xe <= 3'h0;
  endtask
  task t_timer2();
    @(posedge clk); mode <= SC_MODE_OFF; cfb <= 16'h0900; rmp <= 8'h20;
    ccr <= 8'h10; t2 <= 1'b1;
    step(6); chk(b2e_n, 1'b0); chk(b2o, 1'b1); chk(p2, 1'b1);
    @(posedge clk); ccr <= 8'h00; cfb <= 16'h0400; xe[1] <= 1'b1;
    xv[1] <= 1'b0;
    step(6); chk(b2e_n, 1'b1); chk(p2, 1'b0);
    chk(ib2, 1'b0);
  endtask
  task t_debug();
    @(posedge clk); tdo <= 1'b1; tck <= 1'b1;
    step(2); chk(c2e_n, 1'b0); chk(c2o, 1'b1); chk(dclk, 1'b1);
    chk(pd, 1'b1);
    @(posedge clk); dcf <= 8'h20; cfc <= 16'h0100; gc2 <= 1'b0;
    step(6); chk(c2o, 1'b0); chk(ic2, 1'b0);
    @(posedge clk); dcf <= 8'h00; cfc <= 16'h0900; trc <= 1'b1;
    selw <= 1'b1;
    @(posedge clk); selw <= 1'b0;
    wait_wm(1'b1);
    @(posedge clk); atr <= 1'b0; tck <= 1'b0;
    step(2); chk(pd, 1'b0); chk(c2o, 1'b0); chk(pu, 1'b1);
    chk(dclk, 1'b0);
    @(posedge clk); xrst_n <= 1'b0;
    wait_wm(1'b0);
    @(posedge clk); selw <= 1'b1;
    @(posedge clk); selw <= 1'b0;
    step(2); chk(wm, 1'b0); chk(pd, 1'b1);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_n, ms, trc, selw, tck, gb1, gb2, gc2, mosi, miso} = '0;
    {utx, t1, t2, tdo, atr, xe, xv, mode} = '0;
    {sda_n, scl_n, xrst_n} = 3'h7;
    {cfa, cfb, cfc, dcf, rmp, ccr} = '0;
    err_total = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    #1; chk(b1e_n, 1'b1); chk(pd, 1'b1); chk(wm, 1'b0);
    @(posedge clk); rst_n <= 1'b1;
    step(8);
    t_gpio();
    t_spi();
    t_uart();
    t_twi();
    t_timer2();
    t_debug();
    print_verdict();
  end
endmodule

// ===== src/pfm_mux.sv
`timescale 1ns/10ps
// Summary of operation
// - Port B bit 1 drives peripheral output only with alternate config.
// - SPI slave: bit 1 drives slave data out, bit 2 receives data in.
// - SPI master: bit 1 drives master data out, bit 2 receives data in.
// - TWI: bit 1 open-drain data, bit 2 open-drain clock.
// - UART: transmit on bit 1, receive from bit 2.
// - Serial outputs on bit 1 need timer channel off or remap bit 4 clear.
// - Timer channel 1 on bit 1: output needs remap 4, enable, alternate output; input needs remap 4 clear.
// - Timer channel 2 on bit 2 with remap 5; output needs enable, alt.
// - TWI clock on bit 2 needs timer channel 2 off or remap 5 clear.
// - Debug clock pin is wire clock in wire mode, test clock in JTAG.
// - Test clock input gets internal pull-down in JTAG mode.
// - Port C bit 2 is test data out in JTAG mode; plain I/O when debug bit 5 set.
// - Trace out on port C bit 2 needs trace, alt config, wire mode.
// - JTAG mode after reset or external reset low; debugger selects wire.
module pfm_mux
  import pfm_pkg::*;
(
  input  wire logic        clk,                // System clock
  input  wire logic        rst_n,              // Async reset
  // Configuration
  input  wire logic [15:0] port_b_low_config,  // Port B low config
  input  wire logic [15:0] port_a_low_config,  // Port A low config
  input  wire logic [15:0] port_c_low_config,  // Port C low config
  input  wire logic [7:0]  debug_pin_config,   // Debug pin config
  input  wire logic [7:0]  timer2_remap_option_reg,  // Timer 2 remap
  input  wire logic [7:0]  timer2_capcomp_enable_reg, // Timer 2 CC enable
  input  wire logic [1:0]  serctl1_mode_select, // Serial ctl 1 mode
  input  wire logic        serctl1_spi_control, // 1 master, 0 slave
  input  wire logic        trace_async_en,     // Core async trace enable
  // Debug mode control
  input  wire logic        external_reset_pin_n, // Reset pin, raw
  input  wire logic        dbg_select_wire,    // Debugger wire-mode pulse
  // GPIO data
  input  wire logic        gpio_b1_out,        // Port B1 data out
  input  wire logic        gpio_b2_out,        // Port B2 data out
  input  wire logic        gpio_c2_out,        // Port C2 data out
  output logic             gpio_b1_in,         // Port B1 data in
  output logic             gpio_b2_in,         // Port B2 data in
  output logic             gpio_c2_in,         // Port C2 data in
  // Peripheral side
  input  wire logic        serctl1_spi_master_out_slave_in, // Master out
  input  wire logic        serctl1_spi_slave_out_master_in, // Slave out
  input  wire logic        serctl1_uart_tx,    // UART transmit
  input  wire logic        serctl1_twi_data_oe_n,  // Low: pull data low
  input  wire logic        serctl1_twi_clock_oe_n, // Low: pull clock low
  output logic             serctl1_spi_rx,     // SPI data into ctl
  output logic             serctl1_uart_rx,    // UART receive
  output logic             serctl1_twi_data,   // TWI data in
  output logic             serctl1_twi_clock,  // TWI clock in
  input  wire logic        timer2_ch1_out,     // Timer ch1 output
  input  wire logic        timer2_ch2_out,     // Timer ch2 output
  output logic             timer2_channel1_pin, // Timer ch1 input
  output logic             timer2_channel2_pin, // Timer ch2 input
  input  wire logic        jtag_test_data_out, // Core test data out
  input  wire logic        async_trace_out,    // Core trace stream
  output logic             dbg_wire_mode,      // 1 in wire mode
  output logic             dbg_clock,          // Debug clock to core
  // Pads
  input  wire logic        port_b_bit1_pad_i,  // Pad B1 level
  output logic             port_b_bit1_pad_o,  // Pad B1 drive value
  output logic             port_b_bit1_pad_oe_n, // Pad B1 enable, low
  input  wire logic        port_b_bit2_pad_i,  // Pad B2 level
  output logic             port_b_bit2_pad_o,  // Pad B2 drive value
  output logic             port_b_bit2_pad_oe_n, // Pad B2 enable, low
  input  wire logic        port_c_bit2_pad_i,  // Pad C2 level
  output logic             port_c_bit2_pad_o,  // Pad C2 drive value
  output logic             port_c_bit2_pad_oe_n, // Pad C2 enable, low
  output logic             port_c_bit2_pull_up, // Pad C2 pull-up
  input  wire logic        jtag_test_clock_pin, // Debug clock pad
  output logic             jtag_test_clock_pull_down // Pad pull-down
);
  // ---------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------
  function automatic logic is_alt(input logic [3:0] f);
    is_alt = (f == CFG_ALT_OUT) || (f == CFG_ALT_OUT_OD);
  endfunction
  function automatic logic is_out(input logic [3:0] f);
    is_out = (f == CFG_OUT) || (f == CFG_OUT_OD);
  endfunction
  function automatic logic is_od(input logic [3:0] f);
    is_od = (f == CFG_OUT_OD) || (f == CFG_ALT_OUT_OD);
  endfunction

  wire [3:0] b1_cfg = port_b_low_config[B1_FIELD_LSB +: CFG_W];
  wire [3:0] b2_cfg = port_b_low_config[B2_FIELD_LSB +: CFG_W];
  wire [3:0] c2_cfg = port_c_low_config[C2_FIELD_LSB +: CFG_W];
  wire [3:0] c1_cfg = port_a_low_config[T2CH1_FIELD_LSB +: CFG_W];
  wire remap1 = timer2_remap_option_reg[REMAP_C1_BIT];
  wire remap2 = timer2_remap_option_reg[REMAP_C2_BIT];
  wire c1_en  = timer2_capcomp_enable_reg[CCER_C1_BIT];
  wire c2_en  = timer2_capcomp_enable_reg[CCER_C2_BIT];
  wire mode_spi  = serctl1_mode_select == SC_MODE_SPI;
  wire mode_uart = serctl1_mode_select == SC_MODE_UART;
  wire mode_twi  = serctl1_mode_select == SC_MODE_TWI;
  wire spi_master = serctl1_spi_control;

  // ---------------------------------------------------------------
  // Debug mode
  // ---------------------------------------------------------------
  logic     rst_pin_q;
  pfm_dbg_e dbg_r;
  pfm_dbg_e dbg_nxt;

  pfm_sync #(.W(1)) u_rst_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (external_reset_pin_n),
    .q     (rst_pin_q)
  );

  always_comb begin
    case (dbg_r)
      PFM_DBG_JTAG: dbg_nxt = dbg_select_wire ? PFM_DBG_SW : PFM_DBG_JTAG;
      PFM_DBG_SW:   dbg_nxt = PFM_DBG_SW;
      default:      dbg_nxt = PFM_DBG_JTAG;
    endcase
    if (!rst_pin_q) dbg_nxt = PFM_DBG_JTAG;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) dbg_r <= PFM_DBG_JTAG;
    else dbg_r <= dbg_nxt;
  end

  wire jtag_mode = dbg_r == PFM_DBG_JTAG;
  wire sw_mode   = dbg_r == PFM_DBG_SW;
  assign dbg_wire_mode = sw_mode;
  assign dbg_clock = jtag_test_clock_pin;
  assign jtag_test_clock_pull_down = jtag_mode;

  // ---------------------------------------------------------------
  // Port B bit 1
  // ---------------------------------------------------------------
  wire sc_b1_ok  = !c1_en || !remap1;
  wire b1_alt    = is_alt(b1_cfg);
  wire tim1_sel  = remap1 && c1_en && is_alt(c1_cfg) && b1_alt;
  wire spi_b1    = mode_spi && sc_b1_ok && b1_alt;
  wire uart_b1   = mode_uart && sc_b1_ok && b1_alt;
  wire twi_b1    = mode_twi && sc_b1_ok && (b1_cfg == CFG_ALT_OUT_OD);
  wire spi_b1_d  = spi_master ? serctl1_spi_master_out_slave_in
                              : serctl1_spi_slave_out_master_in;
  wire b1_alt_d  = tim1_sel ? timer2_ch1_out :
                   spi_b1   ? spi_b1_d :
                   uart_b1  ? serctl1_uart_tx : 1'b1;
  wire b1_alt_on = tim1_sel || spi_b1 || uart_b1;
  wire b1_nxt_o  = twi_b1 ? 1'b0 : b1_alt_on ? b1_alt_d : gpio_b1_out;
  wire b1_nxt_oe_n =
    twi_b1 ? serctl1_twi_data_oe_n :
    b1_alt_on ? (is_od(b1_cfg) ? b1_alt_d : 1'b0) :
    is_out(b1_cfg) ? (is_od(b1_cfg) ? gpio_b1_out : 1'b0) : 1'b1;

  // ---------------------------------------------------------------
  // Port B bit 2
  // ---------------------------------------------------------------
  wire sc_b2_ok  = !c2_en || !remap2;
  wire b2_alt    = is_alt(b2_cfg);
  wire tim2_sel  = remap2 && c2_en && b2_alt;
  wire twi_b2    = mode_twi && sc_b2_ok && (b2_cfg == CFG_ALT_OUT_OD);
  wire b2_nxt_o  = twi_b2 ? 1'b0 : tim2_sel ? timer2_ch2_out : gpio_b2_out;
  wire b2_nxt_oe_n =
    twi_b2 ? serctl1_twi_clock_oe_n :
    tim2_sel ? (is_od(b2_cfg) ? timer2_ch2_out : 1'b0) :
    is_out(b2_cfg) ? (is_od(b2_cfg) ? gpio_b2_out : 1'b0) : 1'b1;

  // ---------------------------------------------------------------
  // Port C bit 2
  // ---------------------------------------------------------------
  wire c2_gpio   = debug_pin_config[DBG_GPIO_BIT];
  wire trace_sel = !c2_gpio && sw_mode && trace_async_en
                   && is_alt(c2_cfg);
  wire tdo_sel   = !c2_gpio && jtag_mode;
  wire c2_nxt_o  = tdo_sel ? jtag_test_data_out :
                   trace_sel ? async_trace_out : gpio_c2_out;
  wire c2_nxt_oe_n = (tdo_sel || trace_sel) ? 1'b0 :
    (c2_gpio && is_out(c2_cfg)) ?
      (is_od(c2_cfg) ? gpio_c2_out : 1'b0) : 1'b1;
  assign port_c_bit2_pull_up = trace_sel;

  // ---------------------------------------------------------------
  // Pad output registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_b_bit1_pad_o    <= 1'b0;
      port_b_bit1_pad_oe_n <= 1'b1;
      port_b_bit2_pad_o    <= 1'b0;
      port_b_bit2_pad_oe_n <= 1'b1;
      port_c_bit2_pad_o    <= 1'b0;
      port_c_bit2_pad_oe_n <= 1'b1;
    end else begin
      port_b_bit1_pad_o    <= b1_nxt_o;
      port_b_bit1_pad_oe_n <= b1_nxt_oe_n;
      port_b_bit2_pad_o    <= b2_nxt_o;
      port_b_bit2_pad_oe_n <= b2_nxt_oe_n;
      port_c_bit2_pad_o    <= c2_nxt_o;
      port_c_bit2_pad_oe_n <= c2_nxt_oe_n;
    end
  end

  // ---------------------------------------------------------------
  // Pad inputs
  // ---------------------------------------------------------------
  logic [2:0] pad_q;
  pfm_sync #(.W(3)) u_pad_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({port_c_bit2_pad_i, port_b_bit2_pad_i, port_b_bit1_pad_i}),
    .q     (pad_q)
  );
  assign gpio_b1_in = pad_q[0];
  assign gpio_b2_in = pad_q[1];
  assign gpio_c2_in = pad_q[2];
  assign serctl1_spi_rx   = mode_spi ? pad_q[1] : 1'b1;
  assign serctl1_uart_rx  = mode_uart ? pad_q[1] : 1'b1;
  assign serctl1_twi_data  = twi_b1 ? pad_q[0] : 1'b1;
  assign serctl1_twi_clock = twi_b2 ? pad_q[1] : 1'b1;
  assign timer2_channel1_pin = !remap1 ? pad_q[0] : 1'b0;
  assign timer2_channel2_pin = remap2 ? pad_q[1] : 1'b0;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_b1_needs_alt: assert property (
    !port_b_bit1_pad_oe_n && !$past(is_out(b1_cfg))
    |-> $past(b1_alt) || $past(twi_b1)
  ) else $error("B1 driven without alternate config");
  chk_spi_slave_out: assert property (
    spi_b1 && !spi_master && !tim1_sel
    |=> port_b_bit1_pad_o == $past(serctl1_spi_slave_out_master_in)
  ) else $error("B1 not carrying slave out");
  chk_spi_master_out: assert property (
    spi_b1 && spi_master && !tim1_sel
    |=> port_b_bit1_pad_o == $past(serctl1_spi_master_out_slave_in)
  ) else $error("B1 not carrying master out");
  chk_twi_clock_od: assert property (
    twi_b2 |=> port_b_bit2_pad_o == 1'b0
      && port_b_bit2_pad_oe_n == $past(serctl1_twi_clock_oe_n)
  ) else $error("B2 TWI clock not open drain");
  chk_uart_tx: assert property (
    uart_b1 && !tim1_sel |=> port_b_bit1_pad_o == $past(serctl1_uart_tx)
  ) else $error("B1 not carrying UART tx");
  chk_timer_blocks_sc: assert property (
    c1_en && remap1 && !tim1_sel && !is_out(b1_cfg)
    |=> port_b_bit1_pad_oe_n
  ) else $error("Serial output while timer owns B1");
  chk_tim_ch1_out: assert property (
    tim1_sel |=> port_b_bit1_pad_o == $past(timer2_ch1_out)
  ) else $error("Timer ch1 not on B1");
  chk_tim_ch2_out: assert property (
    tim2_sel && !twi_b2 |=> port_b_bit2_pad_o == $past(timer2_ch2_out)
  ) else $error("Timer ch2 not on B2");
  chk_pulldown_jtag: assert property (
    jtag_test_clock_pull_down == (dbg_r == PFM_DBG_JTAG)
  ) else $error("Pull-down mismatch");
  chk_tdo_drive: assert property (
    jtag_mode && !c2_gpio
    |=> !port_c_bit2_pad_oe_n
      && port_c_bit2_pad_o == $past(jtag_test_data_out)
  ) else $error("C2 not driving test data out");
  chk_trace_needs_sw: assert property (
    port_c_bit2_pull_up |-> sw_mode && trace_async_en
  ) else $error("Trace pull-up outside wire mode");
  chk_reset_jtag: assert property (
    !rst_pin_q |=> jtag_mode
  ) else $error("Debug not JTAG during reset pin");

  cov_spi_master: cover property (spi_b1 && spi_master);
  cov_twi_both:   cover property (twi_b1 && twi_b2);
  cov_tim_both:   cover property (tim1_sel && tim2_sel);
  cov_trace:      cover property (trace_sel);
endmodule

// ===== src/pfm_pkg.sv
package pfm_pkg;
  // Port configuration field width and encodings
  localparam int          CFG_W          = 4;
  localparam logic [3:0]  CFG_ANALOG     = 4'h0;
  localparam logic [3:0]  CFG_OUT        = 4'h1;
  localparam logic [3:0]  CFG_OUT_OD     = 4'h5;
  localparam logic [3:0]  CFG_IN         = 4'h4;
  localparam logic [3:0]  CFG_IN_PULL    = 4'h8;
  localparam logic [3:0]  CFG_ALT_OUT    = 4'h9;
  localparam logic [3:0]  CFG_ALT_OUT_OD = 4'hD;
  // Field positions
  localparam int B1_FIELD_LSB    = 4;
  localparam int B2_FIELD_LSB    = 8;
  localparam int C2_FIELD_LSB    = 8;
  localparam int T2CH1_FIELD_LSB = 4;
  localparam int REMAP_C1_BIT  = 4;
  localparam int REMAP_C2_BIT  = 5;
  localparam int DBG_GPIO_BIT  = 5;
  localparam int CCER_C1_BIT   = 0;
  localparam int CCER_C2_BIT   = 4;
  // Serial controller modes
  localparam logic [1:0] SC_MODE_OFF  = 2'h0;
  localparam logic [1:0] SC_MODE_UART = 2'h1;
  localparam logic [1:0] SC_MODE_SPI  = 2'h2;
  localparam logic [1:0] SC_MODE_TWI  = 2'h3;
  // Debug mode states (one-hot)
  typedef enum logic [1:0] {
    PFM_DBG_JTAG = 2'b01,
    PFM_DBG_SW   = 2'b10
  } pfm_dbg_e;
  // Input synchroniser depth
  localparam int SYNC_STAGES = 3;
endpackage

// ===== src/pfm_sync.sv
`timescale 1ns/10ps
// Three-stage pin synchroniser; change accepted when stages 2 and 3 agree
module pfm_sync
  import pfm_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,   // System clock
  input  wire logic         rst_n, // Async reset
  input  wire logic [W-1:0] d,     // Raw pin level
  output logic      [W-1:0] q      // Filtered level
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      assign q_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : q_r[g];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign q = q_r;
endmodule
